// ==== hw/stc_defines.vh ====
// constants for the scan tap timing core
`ifndef STC_DEFINES_VH
`define STC_DEFINES_VH

// widths
`define STC_IR_W 8
`define STC_DR_W 8
`define STC_ST_W 4

// instruction values
`define STC_IR_CAPTURE 8'h81
`define STC_IR_BYPASS 8'hFF

// reset values
`define STC_RST_BYTE 8'h00

// tap controller state codes
`define STC_ST_TLR 4'hF
`define STC_ST_RTI 4'hC
`define STC_ST_SELDR 4'h7
`define STC_ST_CAPDR 4'h6
`define STC_ST_SHDR 4'h2
`define STC_ST_EX1DR 4'h1
`define STC_ST_PAUDR 4'h3
`define STC_ST_EX2DR 4'h0
`define STC_ST_UPDR 4'h5
`define STC_ST_SELIR 4'h4
`define STC_ST_CAPIR 4'hE
`define STC_ST_SHIR 4'hA
`define STC_ST_EX1IR 4'h9
`define STC_ST_PAUIR 4'hB
`define STC_ST_EX2IR 4'h8
`define STC_ST_UPIR 4'hD

// input synchroniser width, one bit per synchronised input
`define STC_SYNC_W 11

`endif

// ==== hw/stc_tap_fsm.v ====
// sixteen-state tap controller stepped by detected rising test clock edges
`timescale 1ns/1ps
`include "stc_defines.vh"

module stc_tap_fsm (
    // clock and reset
    input wire i_ref_clk,
    input wire i_rst,
    // stepping
    input wire i_tck_rise,
    input wire i_tms,
    // state
    output reg [3:0] o_state
);

reg [3:0] next_state;

////////////////////////////////////////////////////////////////////////////////
always @* begin
    next_state = o_state;
    case (o_state)
        `STC_ST_TLR: next_state = i_tms ? `STC_ST_TLR : `STC_ST_RTI;
        `STC_ST_RTI: next_state = i_tms ? `STC_ST_SELDR : `STC_ST_RTI;
        `STC_ST_SELDR: next_state = i_tms ? `STC_ST_SELIR : `STC_ST_CAPDR;
        `STC_ST_CAPDR: next_state = i_tms ? `STC_ST_EX1DR : `STC_ST_SHDR;
        `STC_ST_SHDR: next_state = i_tms ? `STC_ST_EX1DR : `STC_ST_SHDR;
        `STC_ST_EX1DR: next_state = i_tms ? `STC_ST_UPDR : `STC_ST_PAUDR;
        `STC_ST_PAUDR: next_state = i_tms ? `STC_ST_EX2DR : `STC_ST_PAUDR;
        `STC_ST_EX2DR: next_state = i_tms ? `STC_ST_UPDR : `STC_ST_SHDR;
        `STC_ST_UPDR: next_state = i_tms ? `STC_ST_SELDR : `STC_ST_RTI;
        `STC_ST_SELIR: next_state = i_tms ? `STC_ST_TLR : `STC_ST_CAPIR;
        `STC_ST_CAPIR: next_state = i_tms ? `STC_ST_EX1IR : `STC_ST_SHIR;
        `STC_ST_SHIR: next_state = i_tms ? `STC_ST_EX1IR : `STC_ST_SHIR;
        `STC_ST_EX1IR: next_state = i_tms ? `STC_ST_UPIR : `STC_ST_PAUIR;
        `STC_ST_PAUIR: next_state = i_tms ? `STC_ST_EX2IR : `STC_ST_PAUIR;
        `STC_ST_EX2IR: next_state = i_tms ? `STC_ST_UPIR : `STC_ST_SHIR;
        `STC_ST_UPIR: next_state = i_tms ? `STC_ST_SELDR : `STC_ST_RTI;
        default: next_state = `STC_ST_TLR;
    endcase
end

// five high samples reach reset from any state by the diagram itself
always @(posedge i_ref_clk) begin
    if (i_rst) begin
        o_state <= `STC_ST_TLR;
    end else if (i_tck_rise) begin
        o_state <= next_state;
    end
end

endmodule

// ==== hw/stc_tap_core.v ====
// test access port core: tck edge timing, instruction, bypass and data registers
// Functional notes
// - state changes, capture and shift on rising test clock; tdi, tms, function inputs sampled there.
// - serial output and function outputs change only on falling test clock.
// - instruction register loads 10000001 on rising edge leaving capture-ir.
// - serial output driver enabled on falling edge after entering a shift state.
// - in shift-ir the instruction register shifts one bit per rising edge.
// - serial output driver goes high impedance on falling edge in exit1 states.
// - shifted instruction moves to active latch on falling edge in update-ir.
// - all-ones instruction selects bypass register between serial input and output.
// - with bypass active, bypass register loads 0 leaving capture-dr.
// - in update-dr the shifted data moves to the parallel stage on falling edge.
`timescale 1ns/1ps
`include "stc_defines.vh"

module stc_tap_core (
    // clock and reset
    input wire i_ref_clk,
    input wire i_rst,
    // test access port pins
    input wire i_tck,
    input wire i_tms,
    input wire i_tdi,
    output reg o_tdo,
    output reg o_tdo_oe,
    // normal-function pins seen by the data register
    input wire [7:0] i_func_in,
    output reg [7:0] o_func_out,
    // status
    output reg [7:0] o_ir_active,
    output wire [3:0] o_tap_state
);

////////////////////////////////////////////////////////////////////////////////
// input synchronisers: bit 0 tck, bit 1 tms, bit 2 tdi, bits 10..3 function inputs

wire [10:0] raw_in;
reg [10:0] sync1;
reg [10:0] sync2;
reg [10:0] sync3;
reg [10:0] filt;
wire [10:0] next_filt;

assign raw_in = {i_func_in, i_tdi, i_tms, i_tck};

genvar gi;
generate
    for (gi = 0; gi < `STC_SYNC_W; gi = gi + 1) begin : g_sync
        // a change counts only once the second and third stages agree
        assign next_filt[gi] = (sync2[gi] == sync3[gi]) ? sync3[gi] : filt[gi];
        always @(posedge i_ref_clk) begin
            if (i_rst) begin
                sync1[gi] <= 1'b0;
                sync2[gi] <= 1'b0;
                sync3[gi] <= 1'b0;
                filt[gi] <= 1'b0;
            end else begin
                sync1[gi] <= raw_in[gi];
                sync2[gi] <= sync1[gi];
                sync3[gi] <= sync2[gi];
                filt[gi] <= next_filt[gi];
            end
        end
    end
endgenerate

wire tck_rise;
wire tck_fall;
wire tms_s;
wire tdi_s;
wire [7:0] func_s;

// tms and tdi share the tck pipeline depth, so they are seen as set up at the edge
// a tck phase shorter than about two reference clocks is lost in the filter
assign tck_rise = next_filt[0] & ~filt[0];
assign tck_fall = ~next_filt[0] & filt[0];
assign tms_s = next_filt[1];
assign tdi_s = next_filt[2];
assign func_s = next_filt[10:3];

////////////////////////////////////////////////////////////////////////////////
// tap controller

wire [3:0] state;

stc_tap_fsm u_fsm (
    .i_ref_clk (i_ref_clk),
    .i_rst (i_rst),
    .i_tck_rise (tck_rise),
    .i_tms (tms_s),
    .o_state (state)
);

assign o_tap_state = state;

////////////////////////////////////////////////////////////////////////////////
// decoding for the edge paths: bypass select used by both, exit1 test by the falling edge path only

function sel_bypass;
    input [7:0] ir;
    begin
        sel_bypass = (ir == `STC_IR_BYPASS);
    end
endfunction

function in_exit1;
    input [3:0] st;
    begin
        in_exit1 = (st == `STC_ST_EX1IR) || (st == `STC_ST_EX1DR);
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
// rising edge: capture and shift
// pause, exit and update states leave every shift stage untouched

reg [7:0] ir_shift;
reg bypass_bit;
reg [7:0] dr_shift;

always @(posedge i_ref_clk) begin
    if (i_rst) begin
        ir_shift <= `STC_RST_BYTE;
        bypass_bit <= 1'b0;
        dr_shift <= `STC_RST_BYTE;
    end else if (tck_rise) begin
        case (state)
            `STC_ST_CAPIR: begin
                ir_shift <= `STC_IR_CAPTURE;
            end
            `STC_ST_SHIR: begin
                // lsb leaves first, tdi enters at the msb
                ir_shift <= {tdi_s, ir_shift[7:1]};
            end
            `STC_ST_CAPDR: begin
                if (sel_bypass(o_ir_active)) begin
                    bypass_bit <= 1'b0;
                end else begin
                    dr_shift <= func_s;
                end
            end
            `STC_ST_SHDR: begin
                if (sel_bypass(o_ir_active)) begin
                    bypass_bit <= tdi_s;
                end else begin
                    dr_shift <= {tdi_s, dr_shift[7:1]};
                end
            end
            default: begin
                ir_shift <= ir_shift;
            end
        endcase
    end
end

////////////////////////////////////////////////////////////////////////////////
// falling edge: serial output and driver enable

always @(posedge i_ref_clk) begin
    if (i_rst) begin
        o_tdo <= 1'b0;
        o_tdo_oe <= 1'b0;
    end else if (tck_fall) begin
        case (state)
            `STC_ST_TLR: begin
                o_tdo_oe <= 1'b0;
            end
            `STC_ST_SHIR: begin
                o_tdo_oe <= 1'b1;
                o_tdo <= ir_shift[0];
            end
            `STC_ST_SHDR: begin
                o_tdo_oe <= 1'b1;
                if (sel_bypass(o_ir_active)) begin
                    o_tdo <= bypass_bit;
                end else begin
                    o_tdo <= dr_shift[0];
                end
            end
            default: begin
                if (in_exit1(state)) begin
                    o_tdo_oe <= 1'b0;
                end
            end
        endcase
    end
end

////////////////////////////////////////////////////////////////////////////////
// falling edge: update stages, kept apart from the driver path

always @(posedge i_ref_clk) begin
    if (i_rst) begin
        o_func_out <= `STC_RST_BYTE;
        o_ir_active <= `STC_IR_BYPASS;
    end else if (tck_fall) begin
        case (state)
            `STC_ST_TLR: begin
                // reset leaves bypass selected so a chain stays one bit long
                o_ir_active <= `STC_IR_BYPASS;
            end
            `STC_ST_UPIR: begin
                o_ir_active <= ir_shift;
            end
            `STC_ST_UPDR: begin
                // bypass has no parallel stage, so only the data register updates
                if (!sel_bypass(o_ir_active)) begin
                    o_func_out <= dr_shift;
                end
            end
            default: begin
                o_ir_active <= o_ir_active;
            end
        endcase
    end
end

endmodule

// ==== dv/stc_tap_core_properties.sv ====
// assertion checker for the tap core ports
`timescale 1ns/1ps
`include "stc_defines.vh"
module stc_tap_core_properties (
    // clock and reset
    input wire i_ref_clk,
    input wire i_rst,
    // test access port pins
    input wire i_tck,
    input wire i_tms,
    input wire i_tdi,
    input wire o_tdo,
    input wire o_tdo_oe,
    // function pins and status
    input wire [7:0] i_func_in,
    input wire [7:0] o_func_out,
    input wire [7:0] o_ir_active,
    input wire [3:0] o_tap_state
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);
    // set by a capture state, cleared by exit2, so a shift resumed after pause is told apart
    reg via_capture;
    always @(posedge i_ref_clk) begin
        if (i_rst) begin
            via_capture <= 1'b0;
        end else if (o_tap_state == `STC_ST_CAPIR || o_tap_state == `STC_ST_CAPDR) begin
            via_capture <= 1'b1;
        end else if (o_tap_state == `STC_ST_EX2IR || o_tap_state == `STC_ST_EX2DR) begin
            via_capture <= 1'b0;
        end
    end
    // the tck pin is seen 3-4 ref clocks late, so look three clocks back at it
    chk_step_on_rise: assert property (
        $changed(o_tap_state) |-> $past(i_tck, 3)) else $error("state moved off rise");
    chk_tdo_on_fall: assert property (
        $changed(o_tdo) |-> !$past(i_tck, 3)) else $error("tdo moved off fall");
    chk_oe_in_shift: assert property (
        $rose(o_tdo_oe) |-> o_tap_state == `STC_ST_SHIR || o_tap_state == `STC_ST_SHDR)
        else $error("tdo enabled outside shift");
    chk_oe_off_exit: assert property (
        o_tdo_oe && (o_tap_state == `STC_ST_EX1IR || o_tap_state == `STC_ST_EX1DR)
        |-> ##[0:10] !o_tdo_oe) else $error("tdo not released in exit1");
    chk_ir_capture: assert property (
        $rose(o_tdo_oe) && via_capture && o_tap_state == `STC_ST_SHIR |-> o_tdo)
        else $error("ir capture lsb wrong");
    chk_bypass_zero: assert property (
        $rose(o_tdo_oe) && via_capture && o_tap_state == `STC_ST_SHDR
        && o_ir_active == `STC_IR_BYPASS
        |-> !o_tdo) else $error("bypass did not capture zero");
    chk_ir_update: assert property (
        $changed(o_ir_active) |-> o_tap_state == `STC_ST_TLR
        || (o_tap_state == `STC_ST_UPIR && !$past(i_tck, 3))) else $error("ir update misplaced");
    chk_dr_update: assert property (
        $changed(o_func_out) |-> o_tap_state == `STC_ST_UPDR && !$past(i_tck, 3))
        else $error("dr update misplaced");
    chk_shift_exit: assert property (
        $changed(o_tap_state) && $past(o_tap_state) == `STC_ST_SHIR
        |-> o_tap_state == `STC_ST_EX1IR) else $error("bad exit from shift-ir");
endmodule
bind stc_tap_core stc_tap_core_properties chk (.i_ref_clk, .i_rst, .i_tck, .i_tms, .i_tdi,
    .o_tdo, .o_tdo_oe, .i_func_in, .o_func_out, .o_ir_active, .o_tap_state);

// ==== dv/stc_ctl_model.sv ====
// test controller model: drives tck, tms and tdi; tck stands still between frames
`timescale 1ns/1ps
module stc_ctl_model (
    // clock
    input wire i_ref_clk,
    // scan pins
    input wire i_tdo,
    output reg o_tck,
    output reg o_tms,
    output reg o_tdi
);
    initial begin
        o_tck = 1'b0;
        o_tms = 1'b1;
        o_tdi = 1'b0;
    end
    // one 200 ns period entered on a falling ref edge; tdo is read mid high phase
    // it returns at the start of the next period, once the core has acted on the rise,
    // so the caller sees the state that the rise chose
    task cycle(input t_ms, input t_di, output t_do);
        begin
            o_tck = 1'b0;
            o_tms = t_ms;
            o_tdi = t_di;
            repeat (4) @(negedge i_ref_clk);
            o_tck = 1'b1;
            repeat (2) @(negedge i_ref_clk);
            t_do = i_tdo;
            repeat (2) @(negedge i_ref_clk);
        end
    endtask
endmodule

// ==== dv/stc_tap_core_tb.sv ====
// bench for the tap core driven by the test controller model
`timescale 1ns/1ps
`include "stc_defines.vh"
module stc_tap_core_tb;
    reg i_ref_clk = 1'b0;
    reg i_rst = 1'b1;
    reg [7:0] i_func_in = 8'hA5;
    wire tck, tms, tdi, o_tdo, o_tdo_oe;
    wire [7:0] o_func_out, o_ir_active;
    wire [3:0] o_tap_state;
    wire tdo_pin = o_tdo_oe ? o_tdo : 1'bz;
    integer n_errors = 0;
    integer n_tests = 0;
    reg t;
    always #12.5 i_ref_clk = ~i_ref_clk;
    stc_tap_core uut (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_tck(tck), .i_tms(tms),
        .i_tdi(tdi), .o_tdo(o_tdo), .o_tdo_oe(o_tdo_oe), .i_func_in(i_func_in),
        .o_func_out(o_func_out), .o_ir_active(o_ir_active), .o_tap_state(o_tap_state));
    stc_ctl_model ctl (.i_ref_clk(i_ref_clk), .i_tdo(tdo_pin), .o_tck(tck), .o_tms(tms),
        .o_tdi(tdi));
    task check(input [7:0] got, input [7:0] exp);
        begin
            n_tests = n_tests + 1;
            if (got !== exp) begin
                n_errors = n_errors + 1;
                $display("ERROR %0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    task finish_test;
        begin
            if (n_errors == 0 && n_tests > 0) begin
                $display("Run complete: PASS");
            end else begin
                $display("Run complete: FAIL");
            end
            $finish;
        end
    endtask
    task walk(input [4:0] seq, input integer n);
        integer i;
        begin
            for (i = n - 1; i >= 0; i = i - 1) begin
                ctl.cycle(seq[i], 1'b0, t);
            end
        end
    endtask
    // shift n bits lsb first, then leave through exit1 and update
    task shift(input [7:0] din, input [7:0] exp, input integer n);
        integer i;
        begin
            for (i = 0; i < n; i = i + 1) begin
                ctl.cycle(i == n - 1, din[i], t);
                check({7'h00, t}, {7'h00, exp[i]});
            end
            ctl.cycle(1'b1, 1'b0, t);
            check({7'h00, t}, {7'h00, 1'bz});
            walk(5'h01, 1);
            check({4'h0, o_tap_state}, {4'h0, `STC_ST_SELDR});
        end
    endtask
    task t_reset;
        begin
            repeat (6) @(negedge i_ref_clk);
            i_rst = 1'b0;
            @(negedge i_ref_clk);
            check({4'h0, o_tap_state}, {4'h0, `STC_ST_TLR});
            check({7'h00, o_tdo_oe}, 8'h00);
            check(o_func_out, `STC_RST_BYTE);
        end
    endtask
    task t_ir(input [7:0] ins);
        begin
            walk(5'h0C, 5);
            check({4'h0, o_tap_state}, {4'h0, `STC_ST_SHIR});
            shift(ins, `STC_IR_CAPTURE, 8);
            check(o_ir_active, ins);
        end
    endtask
    task t_dr(input [7:0] din, input [7:0] exp, input integer n, input [7:0] par);
        begin
            walk(5'h00, 2);
            shift(din, exp, n);
            check(o_func_out, par);
        end
    endtask
    // five high samples from select-dr must land in reset
    task t_tlr;
        begin
            walk(5'h1F, 5);
            check({4'h0, o_tap_state}, {4'h0, `STC_ST_TLR});
            check(o_ir_active, `STC_IR_BYPASS);
        end
    endtask
    initial begin
        t_reset;
        t_ir(`STC_IR_BYPASS);
        t_dr(8'h05, 8'h02, 3, 8'h00);
        t_tlr;
        t_ir(8'h3C);
        t_dr(8'h96, 8'hA5, 8, 8'h96);
        t_tlr;
        finish_test;
    end
    initial begin
        #500000;
        n_errors = n_errors + 1;
        finish_test;
    end
endmodule
